// ### bench/tb_csctb_top.sv
// Self-checking testbench for the clock select and time base block
`timescale 1ns/100ps
`include "csctb_params.svh"

module tb_csctb_top;
	import csctb_pkg::*;

	// Short divider so the counter stages are reached in a short run
	localparam int DIV = 4;
	// Oscillator settle wait before selecting the fast clock, shortened to keep the run short
	localparam int SETTLE = 20;

	logic MCLK = 1'b0; // Bench clock
	logic RST = 1'b1; // Reset, held at start
	logic [7:0] ADDR = 8'h00; // Register address
	logic [3:0] WDATA = 4'h0; // Write data
	logic WR = 1'b0; // Write strobe
	logic RD = 1'b0; // Read strobe
	logic FAST_SRC_PULSE = 1'b0; // Fast source oscillation
	logic [3:0] RDATA; // Read data
	logic IRQ; // Interrupt level
	logic FAST_OSC_ON; // Oscillator running
	logic OSC_XTAL_MODE; // Crystal mode
	logic CPU_FAST_SEL; // Fast clock selected
	logic FAST_CLK_TICK; // Fast clock tick
	logic SYS_CLK_TICK; // System clock tick
	logic [14:0] TB_COUNT; // Time base counter
	int failures = 0; // Mismatches
	int tests_run = 0; // Comparisons
	logic [14:0] snap; // Counter seen by a read
	logic [3:0] rv; // Value read back
	logic ft; // Fast tick seen
	logic st; // System tick seen

	csctb_top #(.TB_DIV(DIV)) u_csctb_top (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .FAST_SRC_PULSE(FAST_SRC_PULSE), .RDATA(RDATA), .IRQ(IRQ), .FAST_OSC_ON(FAST_OSC_ON),
		.OSC_XTAL_MODE(OSC_XTAL_MODE), .CPU_FAST_SEL(CPU_FAST_SEL), .FAST_CLK_TICK(FAST_CLK_TICK),
		.SYS_CLK_TICK(SYS_CLK_TICK), .TB_COUNT(TB_COUNT));

	// Clock at 125 MHz
	always begin
		#4 MCLK = ~MCLK;
	end

	// Compare and count
	task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One write cycle
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
		// Let the registered result settle before the caller looks
		#1;
	endtask

	// One read cycle; data taken in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge MCLK);
		ADDR <= a;
		RD <= 1'b1;
		#1 snap = TB_COUNT;
		@(posedge MCLK);
		RD <= 1'b0;
		#1 rv = RDATA;
	endtask

	// One fast source pulse and the ticks it gives
	task automatic pulse;
		@(posedge MCLK);
		FAST_SRC_PULSE <= 1'b1;
		@(posedge MCLK);
		FAST_SRC_PULSE <= 1'b0;
		#1 ft = FAST_CLK_TICK;
		st = SYS_CLK_TICK;
	endtask

	// Reset values of control, flags and enables
	task automatic t_reset;
		chk(TB_COUNT, 15'h0000, "count at reset");
		rd(8'h64);
		chk(15'(rv), 15'h0000, "control reset");
		rd(8'h65);
		chk(15'(rv), 15'h0000, "flags reset");
		rd(8'h67);
		chk(15'(rv), 15'h0000, "enable reset");
		rd(8'h70);
		chk(15'(rv), 15'h0000, "unmapped read");
	endtask

	// Control bits, read back and fast clock path
	task automatic t_ctrl;
		pulse;
		chk(15'(ft), 15'h0000, "stopped oscillator ticks");
		wr(8'h64, 4'h2);
		repeat (SETTLE) @(posedge MCLK);
		wr(8'h64, 4'h3);
		pulse;
		chk(15'({ft, st}), 15'h0003, "rc tick direct");
		chk(15'({OSC_XTAL_MODE, FAST_OSC_ON, CPU_FAST_SEL}), 15'h0003, "rc outputs");
		wr(8'h64, 4'h2);
		wr(8'h64, 4'h0);
		wr(8'h64, 4'h6);
		chk(15'({OSC_XTAL_MODE, FAST_OSC_ON, CPU_FAST_SEL}), 15'h0006, "xtal outputs");
		repeat (SETTLE) @(posedge MCLK);
		wr(8'h64, 4'hF);
		rd(8'h64);
		chk(15'(rv), 15'h0007, "control readback");
		pulse;
		chk(15'(ft), 15'h0000, "xtal first pulse");
		pulse;
		chk(15'({ft, st}), 15'h0003, "xtal second pulse");
		pulse;
		chk(15'(ft), 15'h0000, "xtal third pulse");
		wr(8'h64, 4'h6);
		wr(8'h64, 4'h0);
	endtask

	// Counter steps once each divider period
	task automatic t_count;
		logic [14:0] a;
		int k;
		k = 0;
		@(posedge MCLK);
		#1 a = TB_COUNT;
		// Slow clock selected: the system tick follows the divider
		repeat (10 * DIV) begin
			@(posedge MCLK);
			#1 if (SYS_CLK_TICK === 1'b1) k++;
		end
		chk(TB_COUNT - a, 15'd10, "count rate");
		chk(15'(k), 15'h000A, "slow system ticks");
	endtask

	// Natural fall of the 32 Hz stage sets its flag
	task automatic t_fall;
		int n;
		wr(8'h66, 4'hF);
		n = 0;
		while (TB_COUNT[9] !== 1'b1 && n < 9000) begin
			@(posedge MCLK);
			n++;
		end
		while (TB_COUNT[9] !== 1'b0 && n < 9000) begin
			@(posedge MCLK);
			n++;
		end
		chk(15'(n < 9000), 15'h0001, "32 Hz fall reached");
		repeat (2) @(posedge MCLK);
		rd(8'h65);
		chk(15'(rv[3]), 15'h0001, "32 Hz fall flag");
	endtask

	// View reads, view clears and the requests they raise
	task automatic t_clear;
		int n;
		n = 0;
		while ((TB_COUNT & 15'h3600) !== 15'h3600 && n < 70000) begin
			@(posedge MCLK);
			n++;
		end
		chk(15'(n < 70000), 15'h0001, "clear point reached");
		rd(8'h61);
		chk(15'(rv), 15'(snap[14:11]), "low view");
		rd(8'h60);
		chk(15'(rv), 15'(snap[10:7]), "high view");
		wr(8'h66, 4'hF);
		wr(8'h61, 4'h5);
		@(posedge MCLK);
		#1 chk(15'({TB_COUNT[14:11], TB_COUNT[10:9]}), 15'h0003, "low clear");
		rd(8'h65);
		chk(15'(rv), 15'h0003, "low clear flags");
		chk(15'(IRQ), 15'h0000, "masked irq");
		wr(8'h60, 4'hA);
		@(posedge MCLK);
		#1 chk(15'(TB_COUNT[14:7]), 15'h0000, "high clear");
		rd(8'h65);
		chk(15'(rv), 15'h000F, "high clear flags");
		wr(8'h67, 4'h4);
		@(posedge MCLK);
		#1 chk(15'(IRQ), 15'h0001, "enabled irq");
		wr(8'h66, 4'h4);
		@(posedge MCLK);
		#1 chk(15'(IRQ), 15'h0000, "cleared irq");
		rd(8'h65);
		chk(15'(rv), 15'h000B, "other flags kept");
	endtask

	// Verdict and end of run
	task automatic stop_test;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		#1 t_reset;
		t_ctrl;
		t_count;
		t_fall;
		t_clear;
		stop_test;
	end

	// Watchdog against a hang
	initial begin
		repeat (80000) @(posedge MCLK);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		stop_test;
	end
endmodule

// ### verilog/csctb_params.svh
// Register offsets, field positions and counter taps for the clock select and time base block
`ifndef CSCTB_PARAMS_SVH
`define CSCTB_PARAMS_SVH

// Register bus widths
`define CSCTB_ADDR_W 8
`define CSCTB_DATA_W 4

// Register offsets
`define CSCTB_ADDR_TB_HIGH 8'h60
`define CSCTB_ADDR_TB_LOW 8'h61
`define CSCTB_ADDR_CTRL 8'h64
`define CSCTB_ADDR_REQ_STAT 8'h65
`define CSCTB_ADDR_REQ_CLR 8'h66
`define CSCTB_ADDR_REQ_EN 8'h67

// Clock control field positions
`define CSCTB_CTRL_TYPE_BIT 2
`define CSCTB_CTRL_FAST_EN_BIT 1
`define CSCTB_CTRL_CPU_SEL_BIT 0

// Reset values
`define CSCTB_DATA_ZERO 4'h0
`define CSCTB_REQ_RESET 4'h0
`define CSCTB_EN_RESET 4'h0

// Time base counter width and view positions
`define CSCTB_TBC_W 15
`define CSCTB_HIGH_LSB 7
`define CSCTB_LOW_LSB 11

// Counter taps that raise requests
`define CSCTB_TAP_32HZ 9
`define CSCTB_TAP_16HZ 10
`define CSCTB_TAP_4HZ 12
`define CSCTB_TAP_2HZ 13

// Request flag positions
`define CSCTB_REQ_32HZ 3
`define CSCTB_REQ_16HZ 2
`define CSCTB_REQ_4HZ 1
`define CSCTB_REQ_2HZ 0

// Rates for the slow time base clock divider
`define CSCTB_MCLK_HZ 125000000
`define CSCTB_SLOW_HZ 32768

`endif

// ### verilog/csctb_pkg.sv
// Types shared by the clock select and time base block
package csctb_pkg;

	// Fast oscillator type
	typedef enum logic {
		CSCTB_OSC_RC = 1'b0,
		CSCTB_OSC_XTAL = 1'b1
	} csctb_osc_e;

	// Clock control register contents
	typedef struct packed {
		csctb_osc_e osc_type_select;
		logic fast_osc_enable;
		logic cpu_clock_select;
	} csctb_ctrl_s;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] wdata;
		logic wr;
		logic rd;
	} csctb_bus_s;

	// Time base request flags, bit 3 down to bit 0
	typedef logic [3:0] csctb_req_t;

endpackage

// ### verilog/csctb_tbc.sv
// Time base counter with stage clears and falling edge request pulses
`timescale 1ns/100ps
`include "csctb_params.svh"

module csctb_tbc import csctb_pkg::*; #(
	parameter int WIDTH = `CSCTB_TBC_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic clr_high,
	input wire logic clr_low,
	output logic [WIDTH-1:0] count_q,
	output csctb_req_t fall_q
);

	// The taps and views assume the full fifteen stage chain
	if (WIDTH != `CSCTB_TBC_W) begin : g_width_check
		$error("csctb_tbc: WIDTH must be 15");
	end

	logic [WIDTH-1:0] count_d; // Next counter value
	logic [WIDTH-1:0] keep_mask; // Stages not cleared this cycle
	csctb_req_t fall_d; // Falling edges seen this cycle

	// Binary chain: each stage halves the rate of the one below
	always_comb begin
		keep_mask = '1;
		if (clr_high) begin
			keep_mask[WIDTH-1:`CSCTB_HIGH_LSB] = '0;
		end else if (clr_low) begin
			keep_mask[WIDTH-1:`CSCTB_LOW_LSB] = '0;
		end
		// Step on each slow clock falling edge, then clear stages
		count_d = (tick ? count_q + WIDTH'(1) : count_q) & keep_mask;
		// A stage going low, by count or by clear, is a falling edge
		fall_d[`CSCTB_REQ_32HZ] = count_q[`CSCTB_TAP_32HZ] & ~count_d[`CSCTB_TAP_32HZ];
		fall_d[`CSCTB_REQ_16HZ] = count_q[`CSCTB_TAP_16HZ] & ~count_d[`CSCTB_TAP_16HZ];
		fall_d[`CSCTB_REQ_4HZ] = count_q[`CSCTB_TAP_4HZ] & ~count_d[`CSCTB_TAP_4HZ];
		fall_d[`CSCTB_REQ_2HZ] = count_q[`CSCTB_TAP_2HZ] & ~count_d[`CSCTB_TAP_2HZ];
	end

	// Counter and edge pulse registers, cleared by system reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			fall_q <= `CSCTB_REQ_RESET;
		end else begin
			count_q <= count_d;
			fall_q <= fall_d;
		end
	end

	// Count advances by one on a tick when nothing is cleared
	count_step_a: assert property (@(posedge clk) disable iff (rst)
		(tick && !clr_high && !clr_low) |=> count_q == $past(count_q) + WIDTH'(1))
		else $error("time base counter did not step");

	// High clear leaves no upper stage set
	high_clear_a: assert property (@(posedge clk) disable iff (rst)
		clr_high |=> count_q[WIDTH-1:`CSCTB_HIGH_LSB] == '0)
		else $error("high stages not cleared");

endmodule

// ### verilog/csctb_top.sv
// Clock select control, time base counter, request flags and register port
// Notes on behaviour
// - Bit 2 picks RC or crystal; resets zero.
// - Bit 1 starts or stops fast oscillator.
// - Bit 0 routes slow or fast clock.
// - Oscillator starts in currently selected type.
// - Fifteen bit counter on slow clock.
// - Counter starts at zero, steps each falling edge.
// - 32/16/4/2 Hz falls set request bits.
// - Two views show 16-128 and 1-8 Hz.
// - High write clears 1-128 Hz; low clears 1-8 Hz.
// - View write data ignored; only the write matters.
// - Clearing high outputs raises matching requests.
// - Crystal halves the source; RC passes it.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "csctb_params.svh"

module csctb_top import csctb_pkg::*; #(
	parameter int TB_DIV = `CSCTB_MCLK_HZ / `CSCTB_SLOW_HZ
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [`CSCTB_ADDR_W-1:0] ADDR,
	input wire logic [`CSCTB_DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic FAST_SRC_PULSE,
	output logic [`CSCTB_DATA_W-1:0] RDATA,
	output logic IRQ,
	output logic FAST_OSC_ON,
	output logic OSC_XTAL_MODE,
	output logic CPU_FAST_SEL,
	output logic FAST_CLK_TICK,
	output logic SYS_CLK_TICK,
	output logic [`CSCTB_TBC_W-1:0] TB_COUNT
);

	// The divider needs at least two cycles per slow clock period
	if (TB_DIV < 2 || TB_DIV > 65535) begin : g_div_check
		$error("csctb_top: TB_DIV out of range");
	end

	localparam int DIV_W = 16; // Divider counter width

	// Bus request bundle
	csctb_bus_s bus;

	// Address decode strobes
	logic wr_high; // Write to high rate view
	logic wr_low; // Write to low rate view
	logic wr_ctrl; // Write to clock control
	logic wr_clr; // Write to request clear
	logic wr_en; // Write to request enable

	// Slow time base clock divider
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic tb_tick_q; // One cycle per slow clock falling edge
	logic tb_tick_d;

	// Clock control register
	csctb_ctrl_s ctrl_q;
	csctb_ctrl_s ctrl_d;

	// Fast clock generation
	logic half_q; // Crystal mode divide by two phase
	logic half_d;
	logic fast_tick_q; // One cycle per fast clock period
	logic fast_tick_d;
	logic sys_tick_q; // Selected system clock tick
	logic sys_tick_d;

	// Time base counter outputs
	logic [`CSCTB_TBC_W-1:0] tb_count;
	csctb_req_t tb_fall;

	// Request flags, enables and interrupt line
	csctb_req_t req_q;
	csctb_req_t req_d;
	csctb_req_t en_q;
	csctb_req_t en_d;
	logic irq_q;
	logic irq_d;

	// Read data register
	logic [`CSCTB_DATA_W-1:0] rdata_q;
	logic [`CSCTB_DATA_W-1:0] rdata_d;

	// Bundle the bus inputs
	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// Decode write strobes; writes to views carry no data
	always_comb begin
		wr_high = bus.wr && bus.addr == `CSCTB_ADDR_TB_HIGH;
		wr_low = bus.wr && bus.addr == `CSCTB_ADDR_TB_LOW;
		wr_ctrl = bus.wr && bus.addr == `CSCTB_ADDR_CTRL;
		wr_clr = bus.wr && bus.addr == `CSCTB_ADDR_REQ_CLR;
		wr_en = bus.wr && bus.addr == `CSCTB_ADDR_REQ_EN;
	end

	// Slow clock divider: tick marks each falling edge of the slow clock
	always_comb begin
		if (div_q == DIV_W'(TB_DIV - 1)) begin
			div_d = '0;
			tb_tick_d = 1'b1;
		end else begin
			div_d = div_q + DIV_W'(1);
			tb_tick_d = 1'b0;
		end
	end

	// Divider registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			div_q <= '0;
			tb_tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tb_tick_q <= tb_tick_d;
		end
	end

	// Clock control register update
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.osc_type_select = csctb_osc_e'(bus.wdata[`CSCTB_CTRL_TYPE_BIT]);
			ctrl_d.fast_osc_enable = bus.wdata[`CSCTB_CTRL_FAST_EN_BIT];
			ctrl_d.cpu_clock_select = bus.wdata[`CSCTB_CTRL_CPU_SEL_BIT];
		end
	end

	// Control register, cleared by system reset
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= '{osc_type_select: CSCTB_OSC_RC, fast_osc_enable: 1'b0, cpu_clock_select: 1'b0};
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Fast clock: source pulses pass only while the oscillator is enabled
	always_comb begin
		half_d = half_q;
		fast_tick_d = 1'b0;
		if (!ctrl_q.fast_osc_enable) begin
			// Stopped oscillator restarts on a clean phase
			half_d = 1'b0;
		end else if (FAST_SRC_PULSE) begin
			if (ctrl_q.osc_type_select == CSCTB_OSC_XTAL) begin
				// Crystal: every second source pulse
				half_d = ~half_q;
				fast_tick_d = half_q;
			end else begin
				// RC: source drives fast clock directly
				fast_tick_d = 1'b1;
			end
		end
		// Selected system clock; software keeps fast selection legal
		sys_tick_d = ctrl_q.cpu_clock_select ? fast_tick_d : tb_tick_d;
	end

	// Fast clock registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			half_q <= 1'b0;
			fast_tick_q <= 1'b0;
			sys_tick_q <= 1'b0;
		end else begin
			half_q <= half_d;
			fast_tick_q <= fast_tick_d;
			sys_tick_q <= sys_tick_d;
		end
	end

	// Time base counter
	csctb_tbc #(
		.WIDTH(`CSCTB_TBC_W)
	) u_tbc (
		.clk(MCLK),
		.rst(RST),
		.tick(tb_tick_q),
		.clr_high(wr_high),
		.clr_low(wr_low),
		.count_q(tb_count),
		.fall_q(tb_fall)
	);

	// Request flags: a new edge beats a clear in the same cycle
	always_comb begin
		req_d = req_q;
		en_d = en_q;
		if (wr_clr) begin
			req_d = req_q & ~bus.wdata;
		end
		req_d = req_d | tb_fall;
		if (wr_en) begin
			en_d = bus.wdata;
		end
		irq_d = |(req_d & en_d);
	end

	// Flag, enable and interrupt registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			req_q <= `CSCTB_REQ_RESET;
			en_q <= `CSCTB_EN_RESET;
			irq_q <= 1'b0;
		end else begin
			req_q <= req_d;
			en_q <= en_d;
			irq_q <= irq_d;
		end
	end

	// Read data mux; unmapped and write only addresses read zero
	always_comb begin
		rdata_d = `CSCTB_DATA_ZERO;
		if (bus.rd) begin
			unique case (bus.addr)
				`CSCTB_ADDR_TB_HIGH: begin
					rdata_d = tb_count[`CSCTB_HIGH_LSB +: `CSCTB_DATA_W];
				end
				`CSCTB_ADDR_TB_LOW: begin
					rdata_d = tb_count[`CSCTB_LOW_LSB +: `CSCTB_DATA_W];
				end
				`CSCTB_ADDR_CTRL: begin
					rdata_d = {1'b0, ctrl_q};
				end
				`CSCTB_ADDR_REQ_STAT: begin
					rdata_d = req_q;
				end
				`CSCTB_ADDR_REQ_EN: begin
					rdata_d = en_q;
				end
				default: begin
					rdata_d = `CSCTB_DATA_ZERO;
				end
			endcase
		end
	end

	// Read data register; holds zero outside the answer cycle
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rdata_q <= `CSCTB_DATA_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs straight from flip-flops
	assign RDATA = rdata_q;
	assign IRQ = irq_q;
	assign FAST_OSC_ON = ctrl_q.fast_osc_enable;
	assign OSC_XTAL_MODE = ctrl_q.osc_type_select;
	assign CPU_FAST_SEL = ctrl_q.cpu_clock_select;
	assign FAST_CLK_TICK = fast_tick_q;
	assign SYS_CLK_TICK = sys_tick_q;
	assign TB_COUNT = tb_count;

	// Control write sequence
	sequence ctrl_write_s;
		wr_ctrl;
	endsequence

	// Type bit follows the written value
	osc_type_write_a: assert property (@(posedge MCLK) disable iff (RST)
		ctrl_write_s |=> OSC_XTAL_MODE == $past(WDATA[`CSCTB_CTRL_TYPE_BIT]))
		else $error("oscillator type not stored");

	// Enable bit follows the written value
	fast_enable_write_a: assert property (@(posedge MCLK) disable iff (RST)
		ctrl_write_s |=> FAST_OSC_ON == $past(WDATA[`CSCTB_CTRL_FAST_EN_BIT]))
		else $error("oscillator enable not stored");

	// Select bit follows the written value
	cpu_sel_write_a: assert property (@(posedge MCLK) disable iff (RST)
		ctrl_write_s |=> CPU_FAST_SEL == $past(WDATA[`CSCTB_CTRL_CPU_SEL_BIT]))
		else $error("clock select not stored");

	// RC source pulse while running gives a fast tick
	sequence rc_pulse_s;
		FAST_OSC_ON && !OSC_XTAL_MODE && FAST_SRC_PULSE;
	endsequence
	rc_pass_a: assert property (@(posedge MCLK) disable iff (RST)
		rc_pulse_s |=> FAST_CLK_TICK)
		else $error("RC source did not drive fast clock");

	// Crystal: two source pulses never both tick
	xtal_half_a: assert property (@(posedge MCLK) disable iff (RST)
		(FAST_CLK_TICK && OSC_XTAL_MODE) |-> !$past(FAST_CLK_TICK))
		else $error("crystal fast clock not halved");

	// Stopped oscillator gives no fast clock
	fast_stop_a: assert property (@(posedge MCLK) disable iff (RST)
		!FAST_OSC_ON |=> !FAST_CLK_TICK)
		else $error("fast clock while stopped");

	// A fall of the 32 Hz stage sets its request
	tap_fall_a: assert property (@(posedge MCLK) disable iff (RST)
		$fell(tb_count[`CSCTB_TAP_32HZ]) |=> IRQ == |(req_q & en_q) && req_q[`CSCTB_REQ_32HZ])
		else $error("32 Hz request not set");

	// Clearing a high 2 Hz stage raises its request two cycles on
	clear_raise_a: assert property (@(posedge MCLK) disable iff (RST)
		(wr_low && tb_count[`CSCTB_TAP_2HZ]) |-> ##2 req_q[`CSCTB_REQ_2HZ])
		else $error("clear did not raise request");

	// Low view reads return the stages of the read cycle
	view_read_a: assert property (@(posedge MCLK) disable iff (RST)
		(RD && ADDR == `CSCTB_ADDR_TB_LOW) |=> RDATA == $past(tb_count[`CSCTB_LOW_LSB +: `CSCTB_DATA_W]))
		else $error("low view read wrong");

	// Control read returns stored bits
	ctrl_read_a: assert property (@(posedge MCLK) disable iff (RST)
		(RD && ADDR == `CSCTB_ADDR_CTRL) |=> RDATA == {1'b0, $past(ctrl_q)})
		else $error("control read wrong");

endmodule
